/* design/cmd_params.svh */
/*
  Constants of the CSMA/CD MAC datapath: frame lengths, FIFO levels,
  CRC figures and backoff limits. Assumes inclusion by the datapath.
*/
`ifndef CMD_PARAMS_SVH
`define CMD_PARAMS_SVH
`define CMD_FIFO_DEPTH 5'h10
`define CMD_FIFO_OVR 5'h0c
`define CMD_FIFO_LIMIT 5'h0d
`define CMD_RX_FIRST 5'h08
`define CMD_LVL_BYTE 5'h01
`define CMD_LVL_WORD 5'h02
`define CMD_ADDR_BYTES 3'h6
`define CMD_ADDR_LAST 3'h5
`define CMD_BYTE_LAST 3'h7
`define CMD_PRE_BITS 7'h3e
`define CMD_LEAD_LAST 7'h3f
// end counts sit one edge past the last bit, so tx_en still covers it
`define CMD_JAM_LAST 7'h20
`define CMD_FCS_LAST 7'h20
`define CMD_CRC_POLY 32'h04c1_1db7
`define CMD_CRC_INIT 32'hffff_ffff
`define CMD_CRC_RESIDUE 32'hc704_dd7b
`define CMD_SLOT_LAST 10'h1ff
`define CMD_MAX_TRIES 5'h10
`define CMD_BACKOFF_CAP 5'h0a
`define CMD_LFSR_SEED 10'h001
`endif

/* design/cmd_pkg.sv */
/*
  Types of the CSMA/CD MAC datapath: configuration, status pulses and
  state encodings. Assumes nothing of its surroundings.
*/
package cmd_pkg;
  // gray codes along idle, preamble, data, fcs, jam, backoff
  typedef enum logic [2:0] {
    CMD_TX_IDLE = 3'b000,
    CMD_TX_PRE = 3'b001,
    CMD_TX_DATA = 3'b011,
    CMD_TX_FCS = 3'b010,
    CMD_TX_JAM = 3'b110,
    CMD_TX_BACKOFF = 3'b111
  } cmd_tx_state_t;
  typedef enum logic [1:0] {
    CMD_OWN_NONE = 2'b00,
    CMD_OWN_LOCAL = 2'b01,
    CMD_OWN_REMOTE = 2'b11
  } cmd_owner_t;
  typedef struct packed {
    logic [47:0] station_addr;
    logic [63:0] mcast_filter;
    logic accept_all;
    logic word_mode;
    logic [4:0] threshold;
    logic [15:0] ring_start;
    logic [15:0] ring_stop;
    logic [15:0] tx_start;
    logic [15:0] tx_length;
  } cmd_cfg_t;
  typedef struct packed {
    logic frame_ok;
    logic frame_bad;
    logic rejected;
    logic overrun;
  } cmd_rx_status_t;
  typedef struct packed {
    logic done;
    logic collision;
    logic abort;
    logic underrun;
  } cmd_tx_status_t;
endpackage : cmd_pkg

/* design/cmd_mac_datapath.sv */
/*
  Serial MAC datapath: receive deserializer with address filter, CRC,
  transmit serializer with preamble, jam and backoff, 16-byte FIFO and
  local/remote DMA arbitration. Assumes link clocks far slower than clk,
  a memory port with write ready and read valid, and bus_ack on clk.
*/
`timescale 1ns/10ps
`include "cmd_params.svh"
module cmd_mac_datapath
  import cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic rx_clk,
  input wire logic rx_crs,
  input wire logic rx_data,
  input wire logic tx_clk,
  input wire logic tx_col,
  output logic tx_data,
  output logic tx_en,
  input wire cmd_cfg_t cfg,
  input wire logic tx_go,
  input wire logic remote_req,
  output logic remote_grant,
  output logic bus_request_out,
  input wire logic bus_ack,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic mem_ready,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_rvalid,
  output cmd_rx_status_t rx_status,
  output cmd_tx_status_t tx_status,
  output logic [15:0] rx_byte_count
);

  // one serial step of the CRC, shared by both directions
  function automatic logic [31:0] cmd_crc_bit(input logic [31:0] c,
                                              input logic d);
    cmd_crc_bit = {c[30:0], 1'b0} ^
                  ((c[31] ^ d) ? `CMD_CRC_POLY : 32'h0000_0000);
  endfunction : cmd_crc_bit

  function automatic logic cmd_accept(input logic [47:0] dest,
                                      input logic [31:0] crc,
                                      input cmd_cfg_t c);
    if (c.accept_all || (&dest))
      cmd_accept = 1'b1;
    else if (dest[0])
      cmd_accept = c.mcast_filter[crc[31:26]];
    else
      cmd_accept = (dest == c.station_addr);
  endfunction : cmd_accept

  function automatic logic [9:0] cmd_bo_mask(input logic [4:0] n);
    if (n >= `CMD_BACKOFF_CAP)
      cmd_bo_mask = 10'h3ff;
    else
      cmd_bo_mask = (10'h001 << n) - 10'h001;
  endfunction : cmd_bo_mask

  logic [2:0] rxc_s;
  logic [2:0] txc_s;
  logic [1:0] crs_s;
  logic [1:0] rxd_s;
  logic [1:0] col_s;
  logic crs_q;
  logic rx_edge;
  logic tx_edge;
  logic crs_fall;
  logic rx_bit_ok;
  logic rx_sync_hit;
  logic rx_synced;
  logic rx_prev;
  logic [2:0] rx_bits;
  logic [7:0] rx_shift;
  logic [7:0] rx_byte;
  logic [31:0] rx_crc;
  logic rx_push;
  logic [47:0] rx_dest;
  logic [2:0] addr_cnt;
  logic chk_pend;
  logic rx_drop;
  logic rx_reject;
  logic rx_runt;
  logic rx_tail;
  logic rx_first_done;
  logic [7:0] fifo_mem [16];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [4:0] fifo_cnt;
  logic [4:0] fifo_lvl;
  logic fifo_wr;
  logic fifo_rd;
  logic fifo_flush;
  logic [7:0] fifo_wdata;
  logic [7:0] fifo_out;
  cmd_owner_t owner;
  logic local_want;
  logic local_done;
  logic local_grant;
  logic sk_valid;
  logic [7:0] sk_data;
  logic buf_in;
  logic [15:0] rx_wptr;
  logic ring_init;
  logic rd_go;
  logic rd_pend;
  logic [15:0] tx_rem;
  cmd_tx_state_t tx_state;
  logic tx_run;
  logic tx_go_ok;
  logic tx_pop;
  logic tx_restart;
  logic [6:0] tx_bitn;
  logic [7:0] tx_sh;
  logic [31:0] tx_crc;
  logic [15:0] tx_left;
  logic [4:0] tries;
  logic [9:0] slots;
  logic [9:0] slot_bits;
  logic [9:0] lfsr;

  // pin synchronisers; third stage only feeds the edge finders
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxc_s <= 3'h0;
      txc_s <= 3'h0;
      crs_s <= 2'h0;
      rxd_s <= 2'h0;
      col_s <= 2'h0;
      crs_q <= 1'b0;
    end
    else
    begin
      rxc_s <= {rxc_s[1:0], rx_clk};
      txc_s <= {txc_s[1:0], tx_clk};
      crs_s <= {crs_s[0], rx_crs};
      rxd_s <= {rxd_s[0], rx_data};
      col_s <= {col_s[0], tx_col};
      crs_q <= crs_s[1];
    end
  end

  assign rx_edge = rxc_s[1] & ~rxc_s[2];
  assign tx_edge = txc_s[1] & ~txc_s[2];
  assign crs_fall = crs_q & ~crs_s[1];
  assign rx_bit_ok = rx_edge & crs_s[1];
  assign rx_sync_hit = rx_bit_ok & ~rx_synced & rx_prev & rxd_s[1];
  assign rx_byte = {rxd_s[1], rx_shift[7:1]}; // bits arrive lsb first
  assign rx_push = rx_bit_ok & rx_synced & ~rx_drop &
                   (rx_bits == `CMD_BYTE_LAST);
  assign rx_reject = chk_pend & ~cmd_accept(rx_dest, rx_crc, cfg);
  assign rx_runt = crs_fall & rx_synced & ~rx_drop &
                   (addr_cnt != `CMD_ADDR_BYTES);

  // deserializer; preamble bits before the delimiter are dropped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_synced <= 1'b0;
      rx_prev <= 1'b0;
      rx_bits <= 3'h0;
      rx_shift <= 8'h00;
      rx_crc <= `CMD_CRC_INIT;
    end
    else if (crs_fall)
    begin
      rx_synced <= 1'b0;
      rx_prev <= 1'b0;
    end
    else if (rx_sync_hit)
    begin
      rx_synced <= 1'b1;
      rx_bits <= 3'h0;
      rx_crc <= `CMD_CRC_INIT;
    end
    else if (rx_bit_ok && !rx_synced)
      rx_prev <= rxd_s[1];
    else if (rx_bit_ok)
    begin
      rx_shift <= rx_byte;
      rx_bits <= rx_bits + 3'h1;
      rx_crc <= cmd_crc_bit(rx_crc, rxd_s[1]);
    end
  end

  // destination capture, filter verdict and frame bookkeeping
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_dest <= 48'h0000_0000_0000;
      addr_cnt <= 3'h0;
      chk_pend <= 1'b0;
      rx_drop <= 1'b0;
      rx_tail <= 1'b0;
      rx_byte_count <= 16'h0000;
    end
    else if (rx_sync_hit)
    begin
      addr_cnt <= 3'h0;
      rx_drop <= 1'b0;
      rx_tail <= 1'b0;
      rx_byte_count <= 16'h0000;
    end
    else
    begin
      chk_pend <= 1'b0;
      if (rx_push)
      begin
        rx_byte_count <= rx_byte_count + 16'h0001;
        if (addr_cnt != `CMD_ADDR_BYTES)
        begin
          rx_dest <= {rx_byte, rx_dest[47:8]};
          addr_cnt <= addr_cnt + 3'h1;
          chk_pend <= (addr_cnt == `CMD_ADDR_LAST);
        end
      end
      // unicast, multicast hash and broadcast
      if (rx_reject)
        rx_drop <= 1'b1;
      if (rx_runt)
        rx_drop <= 1'b1;
      // accepted frames drain fully, check field included
      if (crs_fall && rx_synced && !rx_drop && !rx_runt)
        rx_tail <= 1'b1;
      else if (rx_tail && fifo_cnt == 5'h00 && !sk_valid)
        rx_tail <= 1'b0;
    end
  end

  // receive status pulses; crc residue judged at carrier drop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rx_status <= '0;
    else
    begin
      rx_status.frame_ok <= crs_fall & rx_synced & ~rx_drop & ~rx_runt &
                            (rx_crc == `CMD_CRC_RESIDUE);
      rx_status.frame_bad <= rx_runt | (crs_fall & rx_synced & ~rx_drop &
                             (rx_crc != `CMD_CRC_RESIDUE));
      rx_status.rejected <= rx_reject;
      rx_status.overrun <= rx_push & ~tx_run &
                           (fifo_cnt >= `CMD_FIFO_OVR);
    end
  end

  // shared FIFO; receive writes stop at 13 bytes, one past the overrun level of 12
  assign fifo_lvl = cfg.threshold + (cfg.word_mode ? `CMD_LVL_WORD
                                                   : `CMD_LVL_BYTE);
  assign fifo_wdata = tx_run ? mem_rdata : rx_byte;
  assign fifo_wr = tx_run ? (rd_pend & mem_rvalid)
                          : (rx_push & (fifo_cnt < `CMD_FIFO_LIMIT));
  assign fifo_rd = buf_in | tx_pop;
  assign fifo_out = fifo_mem[rd_ptr];
  assign tx_go_ok = tx_go & ~tx_run;
  assign fifo_flush = rx_reject | rx_runt | tx_go_ok | tx_restart;

  always_ff @(posedge clk)
  begin
    if (fifo_wr)
      fifo_mem[wr_ptr] <= fifo_wdata;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      fifo_cnt <= 5'h00;
    end
    else if (fifo_flush)
    begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      fifo_cnt <= 5'h00;
    end
    else
    begin
      wr_ptr <= wr_ptr + {3'h0, fifo_wr};
      rd_ptr <= rd_ptr + {3'h0, fifo_rd};
      fifo_cnt <= fifo_cnt + {4'h0, fifo_wr} - {4'h0, fifo_rd};
    end
  end

  // level-driven requests; first receive burst waits for 8 bytes
  assign local_want = tx_run
    ? (tx_rem != 16'h0000 && fifo_cnt < fifo_lvl)
    : (rx_tail ? (fifo_cnt != 5'h00)
       : (!rx_drop && fifo_cnt >= fifo_lvl &&
          (fifo_cnt >= `CMD_RX_FIRST || rx_first_done)));
  assign local_done = tx_run
    ? (!rd_pend && (tx_rem == 16'h0000 || fifo_cnt == `CMD_FIFO_DEPTH))
    : (fifo_cnt == 5'h00 && !sk_valid && !mem_we);
  assign local_grant = (owner == CMD_OWN_LOCAL) & bus_ack;

  // bus arbitration; local always chosen first when both wait
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      owner <= CMD_OWN_NONE;
      bus_request_out <= 1'b0;
      remote_grant <= 1'b0;
      rx_first_done <= 1'b0;
    end
    else
    begin
      if (rx_sync_hit)
        rx_first_done <= 1'b0;
      else if (local_grant && !tx_run)
        rx_first_done <= 1'b1;
      unique case (owner)
        CMD_OWN_NONE:
        begin
          if (bus_request_out && bus_ack)
          begin
            if (local_want)
              owner <= CMD_OWN_LOCAL;
            else if (remote_req)
            begin
              owner <= CMD_OWN_REMOTE;
              remote_grant <= 1'b1;
            end
            else
              bus_request_out <= 1'b0;
          end
          else
            bus_request_out <= (local_want | remote_req) & ~bus_ack;
        end
        CMD_OWN_LOCAL:
        begin
          if (local_done)
          begin
            owner <= CMD_OWN_NONE;
            bus_request_out <= 1'b0;
          end
        end
        CMD_OWN_REMOTE:
        begin
          if (!remote_req)
          begin
            owner <= CMD_OWN_NONE;
            bus_request_out <= 1'b0;
            remote_grant <= 1'b0;
          end
        end
        default:
        begin
          owner <= CMD_OWN_NONE;
          bus_request_out <= 1'b0;
          remote_grant <= 1'b0;
        end
      endcase
    end
  end

  // local DMA: two-entry buffer toward memory, ring walk, transmit reads
  assign buf_in = local_grant & ~tx_run & (fifo_cnt != 5'h00) & ~sk_valid &
                  ~rx_reject & ~rx_runt;
  assign rd_go = local_grant & tx_run & ~rd_pend & (tx_rem != 16'h0000) &
                 (fifo_cnt < `CMD_FIFO_DEPTH) & ~tx_restart;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_we <= 1'b0;
      mem_wdata <= 8'h00;
      mem_addr <= 16'h0000;
      mem_re <= 1'b0;
      sk_valid <= 1'b0;
      sk_data <= 8'h00;
      rx_wptr <= 16'h0000;
      ring_init <= 1'b0;
      rd_pend <= 1'b0;
      tx_rem <= 16'h0000;
    end
    else
    begin
      mem_re <= rd_go;
      ring_init <= 1'b1;
      if (!ring_init)
        rx_wptr <= cfg.ring_start;
      // head register drives memory; skid slot absorbs a stall
      if (!mem_we || mem_ready)
      begin
        mem_we <= sk_valid | buf_in;
        if (sk_valid || buf_in)
        begin
          mem_wdata <= sk_valid ? sk_data : fifo_out;
          mem_addr <= rx_wptr;
          rx_wptr <= (rx_wptr == cfg.ring_stop) ? cfg.ring_start
                                                : rx_wptr + 16'h0001;
        end
        sk_valid <= 1'b0;
      end
      else if (buf_in)
      begin
        sk_valid <= 1'b1;
        sk_data <= fifo_out;
      end
      // transmit loads from programmed pointer and length
      if (tx_go_ok || tx_restart)
      begin
        mem_addr <= cfg.tx_start;
        tx_rem <= cfg.tx_length;
      end
      else if (rd_go)
        rd_pend <= 1'b1;
      else if (rd_pend && mem_rvalid)
      begin
        rd_pend <= 1'b0;
        mem_addr <= mem_addr + 16'h0001;
        tx_rem <= tx_rem - 16'h0001;
      end
    end
  end

  // free-running source of backoff slot counts
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lfsr <= `CMD_LFSR_SEED;
    else
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
  end

  assign tx_pop = tx_edge & (tx_state == CMD_TX_DATA) &
                  (tx_bitn[2:0] == 3'h0) & (fifo_cnt != 5'h00);
  assign tx_restart = tx_edge & (tx_state == CMD_TX_BACKOFF) &
                      (slots == 10'h000) & ~rd_pend;

  // transmit serializer and collision recovery, one step per tx edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state <= CMD_TX_IDLE;
      tx_run <= 1'b0;
      tx_data <= 1'b0;
      tx_en <= 1'b0;
      tx_bitn <= 7'h00;
      tx_sh <= 8'h00;
      tx_crc <= `CMD_CRC_INIT;
      tx_left <= 16'h0000;
      tries <= 5'h00;
      slots <= 10'h000;
      slot_bits <= 10'h000;
      tx_status <= '0;
    end
    else
    begin
      tx_status <= '0;
      if (tx_go_ok)
      begin
        tx_run <= 1'b1;
        tries <= 5'h00;
      end
      if (tx_edge)
      begin
        unique case (tx_state)
          CMD_TX_IDLE:
          begin
            if (tx_run && cfg.tx_length != 16'h0000 && fifo_cnt != 5'h00 &&
                (fifo_cnt >= fifo_lvl || tx_rem == 16'h0000))
            begin
              tx_state <= CMD_TX_PRE;
              tx_en <= 1'b1;
              tx_data <= 1'b1;
              tx_bitn <= 7'h01;
              tx_left <= cfg.tx_length;
              tx_crc <= `CMD_CRC_INIT;
            end
          end
          CMD_TX_PRE:
          begin
            // alternating preamble, then the one-one synch
            tx_data <= (tx_bitn < `CMD_PRE_BITS) ? ~tx_bitn[0] : 1'b1;
            tx_bitn <= tx_bitn + 7'h01;
            if (tx_bitn == `CMD_LEAD_LAST)
            begin
              tx_state <= CMD_TX_DATA;
              tx_bitn <= 7'h00;
            end
          end
          CMD_TX_DATA:
          begin
            if (tx_bitn[2:0] == 3'h0 && fifo_cnt == 5'h00)
            begin
              tx_state <= CMD_TX_IDLE; // starved: give the frame up
              tx_en <= 1'b0;
              tx_run <= 1'b0;
              tx_status.underrun <= 1'b1;
            end
            else
            begin
              tx_data <= (tx_bitn[2:0] == 3'h0) ? fifo_out[0] : tx_sh[0];
              tx_sh <= (tx_bitn[2:0] == 3'h0) ? {1'b0, fifo_out[7:1]}
                                               : {1'b0, tx_sh[7:1]};
              tx_crc <= cmd_crc_bit(tx_crc, (tx_bitn[2:0] == 3'h0)
                        ? fifo_out[0] : tx_sh[0]);
              tx_bitn <= tx_bitn + 7'h01;
              if (tx_bitn[2:0] == `CMD_BYTE_LAST)
              begin
                tx_left <= tx_left - 16'h0001;
                if (tx_left == 16'h0001)
                begin
                  tx_state <= CMD_TX_FCS;
                  tx_bitn <= 7'h00;
                end
              end
            end
          end
          CMD_TX_FCS:
          begin
            tx_data <= ~tx_crc[31]; // msb first
            tx_crc <= {tx_crc[30:0], 1'b1};
            tx_bitn <= tx_bitn + 7'h01;
            if (tx_bitn == `CMD_FCS_LAST)
            begin
              tx_state <= CMD_TX_IDLE;
              tx_run <= 1'b0;
              tx_status.done <= 1'b1;
            end
          end
          CMD_TX_JAM:
          begin
            tx_data <= 1'b1;
            tx_bitn <= tx_bitn + 7'h01;
            if (tx_bitn == `CMD_JAM_LAST)
            begin
              tries <= tries + 5'h01;
              slots <= lfsr & cmd_bo_mask(tries + 5'h01);
              slot_bits <= 10'h000;
              tx_state <= CMD_TX_BACKOFF;
              if (tries + 5'h01 == `CMD_MAX_TRIES)
              begin
                tx_state <= CMD_TX_IDLE;
                tx_run <= 1'b0;
                tx_status.abort <= 1'b1;
              end
            end
          end
          CMD_TX_BACKOFF:
          begin
            tx_en <= 1'b0;
            tx_data <= 1'b0;
            if (tx_restart)
              tx_state <= CMD_TX_IDLE; // retry refills from the start
            else if (slots != 10'h000)
            begin
              slot_bits <= slot_bits + 10'h001;
              if (slot_bits == `CMD_SLOT_LAST)
                slots <= slots - 10'h001;
            end
          end
          default:
          begin
            tx_state <= CMD_TX_IDLE;
            tx_en <= 1'b0;
          end
        endcase
        // collision seen while sending: swap to jam
        if (col_s[1] && (tx_state == CMD_TX_PRE ||
            tx_state == CMD_TX_DATA || tx_state == CMD_TX_FCS))
        begin
          tx_state <= CMD_TX_JAM;
          tx_data <= 1'b1;
          tx_bitn <= 7'h01;
          tx_status.collision <= 1'b1;
        end
      end
      if (tx_state == CMD_TX_JAM && tx_bitn == `CMD_JAM_LAST && tx_edge)
        tx_en <= 1'b0;
      if (tx_state == CMD_TX_FCS && tx_bitn == `CMD_FCS_LAST && tx_edge)
        tx_en <= 1'b0;
    end
  end

endmodule : cmd_mac_datapath

/* testbench/cmd_chk_props.sv */
/* port assertions of the mac datapath
   assumes a bind onto cmd_mac_datapath */
`timescale 1ns/10ps
module cmd_chk
  import cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_request_out,
  input wire logic bus_ack,
  input wire logic remote_grant,
  input wire logic mem_we,
  input wire logic mem_ready,
  input wire logic mem_re,
  input wire logic [15:0] mem_addr,
  input wire logic tx_en,
  input wire cmd_rx_status_t rx_status,
  input wire cmd_tx_status_t tx_status,
  input wire logic [15:0] rx_byte_count
);
  // single domain, bus clock
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_req_ack: assert property (
    $rose(bus_request_out) |-> !$past(bus_ack)) else $error("req on ack");
  chk_we_hold: assert property (
    mem_we && !mem_ready |=> mem_we && $stable(mem_addr))
    else $error("write dropped");
  chk_remote_idle: assert property (
    remote_grant |-> !mem_we && !mem_re) else $error("local under remote");
  chk_ok_pulse: assert property (
    rx_status.frame_ok |=> !rx_status.frame_ok) else $error("ok not pulse");
  chk_ok_bad: assert property (
    rx_status.frame_ok |-> !rx_status.frame_bad) else $error("ok and bad");
  chk_count_step: assert property (
    rx_byte_count != $past(rx_byte_count) && rx_byte_count != 16'h0000
    |-> rx_byte_count == $past(rx_byte_count) + 16'h0001)
    else $error("count jump");
  chk_done_idle: assert property (
    tx_status.done |-> !tx_en) else $error("done while sending");
  chk_rej_flush: assert property (
    rx_status.rejected |-> !mem_we) else $error("rejected stored");
  cov_ok: cover property (rx_status.frame_ok);
  cov_done: cover property (tx_status.done);
  cov_rem: cover property (remote_grant);
endmodule : cmd_chk
bind cmd_mac_datapath cmd_chk u_cmd_chk (.clk, .rstn, .bus_request_out,
  .bus_ack, .remote_grant, .mem_we, .mem_ready, .mem_re, .mem_addr, .tx_en,
  .rx_status, .tx_status, .rx_byte_count);

/* testbench/cmd_phy.sv */
/* serial link partner: receive frames and a free transmit clock
   assumes the bench calls send between frames */
`timescale 1ns/10ps
module cmd_phy
(
  output logic rx_clk,
  output logic rx_crs,
  output logic rx_data,
  output logic tx_clk,
  output logic tx_col
);
  // transmit clock free, phase unrelated to clk
  initial
  begin
    {rx_clk, rx_crs, rx_data, tx_col} = 4'h0;
    tx_clk = 1'b0;
    #37;
    forever #80 tx_clk = ~tx_clk;
  end
  // data set while clock low, taken on the rise
  task automatic put(input logic b);
    rx_data = b;
    #80 rx_clk = 1'b1;
    #80 rx_clk = 1'b0;
  endtask : put
  // clock stands still outside frames; idle data inverted
  task automatic send(input logic [7:0] q[$], input logic [31:0] f);
    rx_crs = 1'b1;
    for (int i = 0; i < 64; i++)
      put(i > 61 || !i[0]);
    foreach (q[i])
      for (int k = 0; k < 8; k++)
        put(q[i][k]);
    for (int k = 31; k >= 0; k--)
      put(f[k]);
    #80 rx_crs = 1'b0;
    rx_data = ~rx_data;
  endtask : send
  // collision level seen on the medium
  task automatic collide(input logic c);
    tx_col = c;
  endtask : collide
endmodule : cmd_phy

/* testbench/tb_top.sv */
/* self-checking bench of the mac datapath
   assumes the link partner and a stalling memory */
`timescale 1ns/10ps
module tb_top
  import cmd_pkg::*;
;
  logic clk, rstn, rx_clk, rx_crs, rx_data, tx_clk, tx_col, tx_data, tx_en;
  logic tx_go, remote_req, remote_grant, bus_request_out, bus_ack;
  logic mem_we, mem_ready, mem_re, mem_rvalid;
  logic [15:0] mem_addr, rx_byte_count;
  logic [7:0] mem_wdata, mem_rdata;
  logic tx_bits [0:511];
  logic [7:0] wr_log [0:31];
  cmd_cfg_t cfg;
  cmd_rx_status_t rx_status;
  cmd_tx_status_t tx_status;
  int num_errors, cmp_count, n_ok, n_bad, n_rej, n_wr, n_tx, n_done, n_col;
  cmd_mac_datapath u_cmd_mac_datapath (.clk, .rstn, .rx_clk, .rx_crs,
    .rx_data, .tx_clk, .tx_col, .tx_data, .tx_en, .cfg, .tx_go, .remote_req,
    .remote_grant, .bus_request_out, .bus_ack, .mem_addr, .mem_wdata, .mem_we,
    .mem_ready, .mem_re, .mem_rdata, .mem_rvalid, .rx_status, .tx_status,
    .rx_byte_count);
  cmd_phy u_cmd_phy (.rx_clk, .rx_crs, .rx_data, .tx_clk, .tx_col);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // memory answers on the falling edge and stalls every other cycle
  always @(negedge clk)
  begin
    bus_ack <= bus_request_out;
    mem_ready <= ~mem_ready;
    mem_rvalid <= mem_re;
    mem_rdata <= mem_re ? mem_addr[7:0] : ~mem_rdata;
  end
  // tallies of what the design showed at each rising edge
  always @(posedge clk)
  begin
    if (mem_we && mem_ready && n_wr < 32)
      wr_log[n_wr] <= mem_wdata;
    n_wr <= n_wr + (mem_we && mem_ready);
    n_done <= n_done + tx_status.done;
    n_col <= n_col + tx_status.collision;
    n_ok <= n_ok + rx_status.frame_ok;
    n_bad <= n_bad + rx_status.frame_bad;
    n_rej <= n_rej + rx_status.rejected;
  end
  // sampled mid bit, well after the data change
  always @(negedge tx_clk)
    if (tx_en === 1'b1 && n_tx < 512)
    begin
      tx_bits[n_tx] = tx_data;
      n_tx++;
    end
  task automatic cmp(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : cmp
  function automatic logic [31:0] fcs_of(input logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hffff_ffff;
    foreach (q[i])
      for (int k = 0; k < 8; k++)
        c = {c[30:0], 1'b0} ^ (c[31] ^ q[i][k] ? 32'h04c1_1db7 : 32'h0);
    return ~c;
  endfunction : fcs_of
  // 14 bytes after delimiter plus check field; d fills the destination
  task automatic rx_case(input logic [7:0] d, input logic [31:0] x,
    input int ok, bad, rej, wr);
    logic [7:0] q[$];
    logic [31:0] f, r;
    for (int i = 0; i < 14; i++)
      q.push_back(i < 6 ? d : 8'(i));
    f = fcs_of(q) ^ x;
    r = {<<{f}};
    {n_ok, n_bad, n_rej, n_wr} = '0;
    u_cmd_phy.send(q, f);
    repeat (150) @(negedge clk);
    cmp("rejected", 16'(rej), 16'(n_rej));
    cmp("writes", 16'(wr), 16'(n_wr));
    cmp("frame_ok", 16'(ok), 16'(n_ok));
    cmp("frame_bad", 16'(bad), 16'(n_bad));
    if (rej == 0)
      cmp("byte count", 16'd18, rx_byte_count);
    for (int i = 0; i < wr; i++)
      cmp("wdata", i < 14 ? q[i] : r[8 * i - 112 +: 8], wr_log[i]);
  endtask : rx_case
  task automatic t_bcast;
    rx_case(8'hff, 32'h0, 1, 0, 0, 18);
  endtask : t_bcast
  task automatic t_badcrc;
    rx_case(8'hff, 32'h0000_0100, 0, 1, 0, 18);
  endtask : t_badcrc
  task automatic t_ucast;
    rx_case(8'h22, 32'h0, 0, 0, 1, 0);
  endtask : t_ucast
  // hashed filter bit of the destination cleared, then alone set
  task automatic t_mcast;
    logic [7:0] d[$];
    logic [31:0] c;
    for (int i = 0; i < 6; i++)
      d.push_back(8'h03);
    c = ~fcs_of(d);
    cfg.mcast_filter = ~(64'h1 << c[31:26]);
    rx_case(8'h03, 32'h0, 0, 0, 1, 0);
    cfg.mcast_filter = 64'h1 << c[31:26];
    rx_case(8'h03, 32'h0, 1, 0, 0, 18);
  endtask : t_mcast
  // 16 bytes read from addresses 0..15 come back as their address;
  // a nonzero cut raises collision once cut bits are out
  task automatic tx_case(input int cut);
    logic [7:0] q[$];
    logic [31:0] f;
    int b;
    for (int i = 0; i < 16; i++)
      q.push_back(8'(i));
    f = fcs_of(q);
    b = (cut > 0) ? cut + 32 : 0;
    {n_tx, n_done, n_col} = '0;
    tx_go = 1'b1;
    @(negedge clk) tx_go = 1'b0;
    for (int w = 0; w < 20000 && n_tx < b + 224; w++)
    begin
      @(negedge clk);
      u_cmd_phy.collide(cut > 0 && n_tx >= cut && n_tx < b);
    end
    repeat (200) @(negedge clk);
    cmp("tx bits", 16'(b + 224), 16'(n_tx));
    cmp("collisions", 16'(cut > 0), 16'(n_col));
    cmp("done", 16'h0001, 16'(n_done));
    for (int i = 0; i < cut; i++)
      cmp("lead cut", 16'(!i[0]), 16'(tx_bits[i]));
    for (int i = cut; i < b; i++)
      cmp("jam", 16'h0001, 16'(tx_bits[i]));
    for (int i = 0; i < 64; i++)
      cmp("lead", 16'(i > 61 || !i[0]), 16'(tx_bits[b + i]));
    for (int i = 0; i < 128; i++)
      cmp("data", 16'((i >> 3) >> (i % 8) & 1),
        16'(tx_bits[b + 64 + i]));
    for (int i = 0; i < 32; i++)
      cmp("fcs", 16'(f[31 - i]),
        16'(tx_bits[b + 192 + i]));
  endtask : tx_case
  task automatic t_tx;
    tx_case(0);
  endtask : t_tx
  // collision in the preamble: jam, backoff, then a full retry
  task automatic t_collide;
    tx_case(10);
  endtask : t_collide
  task automatic t_remote;
    remote_req = 1'b1;
    for (int w = 0; w < 50 && remote_grant !== 1'b1; w++)
      @(negedge clk);
    cmp("remote on", 16'h0001, 16'(remote_grant));
    remote_req = 1'b0;
    repeat (5) @(negedge clk);
    cmp("remote off", 16'h0000, 16'(remote_grant));
  endtask : t_remote
  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial
  begin
    {rstn, tx_go, remote_req, bus_ack, mem_ready, mem_rvalid} = '0;
    mem_rdata = 8'h00;
    cfg = '{48'h1111_1111_1111, 64'h0, 1'b0, 1'b0, 5'h08, 16'h0100,
      16'h01ff, 16'h0000, 16'h0010};
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_bcast;
    t_badcrc;
    t_ucast;
    t_mcast;
    t_tx;
    t_collide;
    t_remote;
    give_verdict;
  end
  // about twice the expected run, backoff included
  initial
  begin
    #600_000;
    num_errors++;
    give_verdict;
  end
endmodule : tb_top
